/* logic/dinh_blink.sv */
`timescale 1ns/1ns
`include "dinh_defines.svh"
// Blink-code generator: count blinks, then pause, repeat while requested
module dinh_blink #(
    parameter int MS_CYC = `DINH_MS_CYC
) (
    input wire logic clk_sys,
    input wire logic srst,
    dinh_blink_if.gen bl
);
    typedef enum logic [2:0] {DINH_BS_IDLE, DINH_BS_ON, DINH_BS_OFF, DINH_BS_MID,
        DINH_BS_GAP} dinh_bstate_t;
    dinh_bstate_t st_r, st_nxt;
    logic [31:0] tmr_r, tmr_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic dig_r, dig_nxt;
    logic lamp_r, lamp_nxt;
    logic alt;
    logic [31:0] on_c, off_c, gap_c;

    // Timing per style; the two basic styles differ only here
    always_comb begin
        alt = (bl.style == 3'(dinh_pkg::DINH_STY_ALT));
        on_c = 32'((alt ? `DINH_ALT_ON_MS : `DINH_STD_ON_MS) * MS_CYC);
        off_c = 32'((alt ? `DINH_ALT_OFF_MS : `DINH_STD_OFF_MS) * MS_CYC);
        gap_c = 32'((alt ? `DINH_ALT_GAP_MS : `DINH_STD_GAP_MS) * MS_CYC);
    end

    // Sequencer next state
    always_comb begin
        st_nxt = st_r;
        tmr_nxt = tmr_r;
        cnt_nxt = cnt_r;
        dig_nxt = dig_r;
        if (!bl.req) begin
            st_nxt = DINH_BS_IDLE;
        end else begin
            unique case (st_r)
                DINH_BS_IDLE: begin
                    st_nxt = DINH_BS_ON;
                    tmr_nxt = 32'h0;
                    cnt_nxt = 4'h1;
                    dig_nxt = 1'b0;
                end
                DINH_BS_ON: begin
                    tmr_nxt = tmr_r + 32'h1;
                    if (tmr_r >= on_c - 32'h1) begin
                        st_nxt = DINH_BS_OFF;
                        tmr_nxt = 32'h0;
                    end
                end
                DINH_BS_OFF: begin
                    tmr_nxt = tmr_r + 32'h1;
                    if (tmr_r >= off_c - 32'h1) begin
                        tmr_nxt = 32'h0;
                        if (cnt_r < (dig_r ? bl.code_lo : bl.code_hi)) begin
                            st_nxt = DINH_BS_ON;
                            cnt_nxt = cnt_r + 4'h1;
                        end else if (!dig_r && bl.code_lo != 4'h0) begin
                            st_nxt = DINH_BS_MID; // Digit separator
                        end else begin
                            st_nxt = DINH_BS_GAP;
                        end
                    end
                end
                DINH_BS_MID: begin
                    tmr_nxt = tmr_r + 32'h1;
                    if (tmr_r >= off_c - 32'h1) begin
                        st_nxt = DINH_BS_ON;
                        tmr_nxt = 32'h0;
                        cnt_nxt = 4'h1;
                        dig_nxt = 1'b1;
                    end
                end
                DINH_BS_GAP: begin
                    tmr_nxt = tmr_r + 32'h1;
                    if (tmr_r >= gap_c - 32'h1) begin
                        st_nxt = DINH_BS_IDLE; // Repeat the code
                    end
                end
                default: st_nxt = DINH_BS_IDLE;
            endcase
        end
        // Lamp lit for exactly the on-state cycles
        lamp_nxt = (st_nxt == DINH_BS_ON);
    end

    // Registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_r <= DINH_BS_IDLE;
            tmr_r <= 32'h0;
            cnt_r <= 4'h0;
            dig_r <= 1'b0;
            lamp_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
            cnt_r <= cnt_nxt;
            dig_r <= dig_nxt;
            lamp_r <= lamp_nxt;
        end
    end

    assign bl.lamp = lamp_r;
endmodule : dinh_blink

/* logic/dinh_blink_if.sv */
`timescale 1ns/1ns
// Request from the core to the blink generator
interface dinh_blink_if;
    logic req;
    logic [2:0] style;
    logic [3:0] code_hi;
    logic [3:0] code_lo;
    logic lamp;
    modport core (output req, output style, output code_hi, output code_lo, input lamp);
    modport gen (input req, input style, input code_hi, input code_lo, output lamp);
endinterface : dinh_blink_if

/* logic/dinh_debounce.sv */
`timescale 1ns/1ns
`include "dinh_defines.svh"
// Two-stage sync plus stable-count filter for one 2-bit pin level
module dinh_debounce #(
    parameter int DEB_CYC = `DINH_DEB_CYC
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [1:0] pin_raw,
    output logic [1:0] pin_clean
);
    logic [1:0] s1_r, s2_r, s1_nxt, s2_nxt, clean_r, clean_nxt;
    logic [19:0] cnt_r, cnt_nxt;

    // Filter next state
    always_comb begin
        s1_nxt = pin_raw;
        s2_nxt = s1_r;
        clean_nxt = clean_r;
        cnt_nxt = 20'h0;
        if (s2_r != clean_r) begin
            if (cnt_r >= 20'(DEB_CYC - 1)) begin
                clean_nxt = s2_r;
            end else begin
                cnt_nxt = cnt_r + 20'h1;
            end
        end
    end

    // Registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s1_r <= 2'h0;
            s2_r <= 2'h0;
            clean_r <= 2'h0;
            cnt_r <= 20'h0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            clean_r <= clean_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign pin_clean = clean_r;
endmodule : dinh_debounce

/* logic/dinh_defines.svh */
`ifndef DINH_DEFINES_SVH
`define DINH_DEFINES_SVH

// --------
// Register offsets
// --------
`define DINH_OFF_CFG0 12'h000
`define DINH_OFF_CFG1 12'h004
`define DINH_OFF_CTRL 12'h008
`define DINH_OFF_STAT 12'h00c

// --------
// Field positions
// --------
`define DINH_CFG_FN_LSB 0
`define DINH_CFG_ACT_LSB 2
`define DINH_CFG_LATCH_BIT 5
`define DINH_CFG_FLASH_BIT 6
`define DINH_CFG_FIELD_W 8
`define DINH_CTRL_LIMIT_LSB 0
`define DINH_CTRL_STYLE_LSB 8

// --------
// Reset values and limit maximum
// --------
`define DINH_RST_CFG 32'h0000_0000
`define DINH_RST_LIMIT 7'h64
`define DINH_RST_STYLE 3'h0
`define DINH_LIMIT_MAX 7'h64

// --------
// Timing, milliseconds, and cycle counts at 50 MHz
// --------
`define DINH_CLK_HZ 50000000
`define DINH_MS_CYC (`DINH_CLK_HZ / 1000)
`define DINH_STD_ON_MS 250
`define DINH_STD_OFF_MS 500
`define DINH_STD_GAP_MS 2000
`define DINH_ALT_ON_MS 140
`define DINH_ALT_OFF_MS 400
`define DINH_ALT_GAP_MS 2400
`define DINH_DEB_MS 10
`define DINH_DEB_CYC (`DINH_DEB_MS * `DINH_MS_CYC)

// --------
// Blink codes
// --------
`define DINH_CODE_STD_INH 4'h6
`define DINH_CODE_ALT2_INH 4'h1
`define DINH_CODE_T3_INH 4'h6
`define DINH_CODE_T4_HI 4'h3
`define DINH_CODE_T4_LO 4'h1

`endif

/* logic/dinh_pkg.sv */
package dinh_pkg;

    // Active-state decoding choices
    typedef enum logic [2:0] {
        DINH_ACT_LOW,
        DINH_ACT_HIGH,
        DINH_ACT_OPEN,
        DINH_ACT_LOW_HIGH,
        DINH_ACT_LOW_OPEN,
        DINH_ACT_HIGH_OPEN
    } dinh_act_t;

    // Input functions handled here
    typedef enum logic [1:0] {
        DINH_FN_NONE,
        DINH_FN_CHG_INH,
        DINH_FN_SLOW,
        DINH_FN_SLOW_STOP
    } dinh_fn_t;

    // Blink styles
    typedef enum logic [2:0] {
        DINH_STY_STD,
        DINH_STY_ALT2,
        DINH_STY_T3,
        DINH_STY_T4,
        DINH_STY_ALT
    } dinh_style_t;

    // Sensed pin level
    typedef enum logic [1:0] {
        DINH_PIN_OPEN,
        DINH_PIN_DOWN,
        DINH_PIN_UP,
        DINH_PIN_MID
    } dinh_pin_t;

endpackage : dinh_pkg

/* logic/dinh_top.sv */
`timescale 1ns/1ns
`include "dinh_defines.svh"

module dinh_top #(
    parameter int NPIN = 2,
    parameter int DEB_CYC = `DINH_DEB_CYC,
    parameter int MS_CYC = `DINH_MS_CYC
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [NPIN*2-1:0] pin_level,
    input wire logic throttle_deflected,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic drive_inhibit,
    output logic emergency_decel,
    output logic park_brake,
    output logic normal_decel,
    output logic speed_limit_en,
    output logic [6:0] slow_limit_percent,
    output logic out_of_neutral_power_up_check,
    output logic out_of_neutral_power_up_check_fault,
    output logic status_lamp
);
    // --------
    // Declarations
    // --------
    logic [31:0] cfg_r, cfg_nxt;
    logic [6:0] limit_r, limit_nxt;
    logic [2:0] style_r, style_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [NPIN-1:0] act, inh_act, slow_act, latched_r, latched_nxt, flash_want;
    logic [NPIN*2-1:0] clean;
    logic hold_r, hold_nxt, fault_r, fault_nxt, check_r, check_nxt;
    logic inh_r, inh_nxt, edec_r, edec_nxt, brake_r, brake_nxt;
    logic ndec_r, ndec_nxt, slim_r, slim_nxt, lamp_r;
    logic any_inh, any_slow, prev_inh_r, inh_rise;
    logic acc;
    dinh_blink_if bl();

    // --------
    // Per-pin decode
    // --------
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            logic [7:0] f;
            dinh_pkg::dinh_pin_t lv;
            dinh_pkg::dinh_act_t ac;
            dinh_pkg::dinh_fn_t fn;
            logic up, dn, op;

            // Synchronise and filter first
            dinh_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
                .clk_sys(clk_sys),
                .srst(srst),
                .pin_raw(pin_level[g*2 +: 2]),
                .pin_clean(clean[g*2 +: 2])
            );

            assign f = cfg_r[g*`DINH_CFG_FIELD_W +: `DINH_CFG_FIELD_W];
            assign lv = dinh_pkg::dinh_pin_t'(clean[g*2 +: 2]);
            assign ac = dinh_pkg::dinh_act_t'(f[`DINH_CFG_ACT_LSB +: 3]);
            assign fn = dinh_pkg::dinh_fn_t'(f[`DINH_CFG_FN_LSB +: 2]);
            assign up = (lv == dinh_pkg::DINH_PIN_UP);
            assign dn = (lv == dinh_pkg::DINH_PIN_DOWN);
            assign op = (lv == dinh_pkg::DINH_PIN_OPEN);

            // Active-state decode
            always_comb begin
                unique case (ac)
                    dinh_pkg::DINH_ACT_LOW: act[g] = dn;
                    dinh_pkg::DINH_ACT_HIGH: act[g] = up;
                    dinh_pkg::DINH_ACT_OPEN: act[g] = op;
                    dinh_pkg::DINH_ACT_LOW_HIGH: act[g] = dn | up;
                    dinh_pkg::DINH_ACT_LOW_OPEN: act[g] = dn | op;
                    dinh_pkg::DINH_ACT_HIGH_OPEN: act[g] = up | op;
                    default: act[g] = 1'b0;
                endcase
            end

            // Function dispatch
            always_comb begin
                inh_act[g] = 1'b0;
                slow_act[g] = 1'b0;
                unique case (fn)
                    dinh_pkg::DINH_FN_CHG_INH: inh_act[g] = act[g];
                    dinh_pkg::DINH_FN_SLOW: slow_act[g] = act[g];
                    dinh_pkg::DINH_FN_SLOW_STOP: begin
                        // Only high or low valid
                        if (ac == dinh_pkg::DINH_ACT_HIGH || ac == dinh_pkg::DINH_ACT_LOW) begin
                            // Full pull stops, resistor level slows
                            inh_act[g] = act[g];
                            slow_act[g] = (lv == dinh_pkg::DINH_PIN_MID);
                        end
                    end
                    default: ;
                endcase
            end

            // Latch only inhibiting functions
            assign latched_nxt[g] = latched_r[g] | (inh_act[g] & f[`DINH_CFG_LATCH_BIT]);
            // Flash request per pin
            assign flash_want[g] = f[`DINH_CFG_FLASH_BIT] &
                (latched_r[g] | (inh_act[g] & (f[`DINH_CFG_LATCH_BIT] | throttle_deflected)));
        end
    endgenerate

    // --------
    // Drive control
    // --------
    assign any_inh = |inh_act;
    assign any_slow = |slow_act;
    assign inh_rise = any_inh & ~prev_inh_r;

    // Inhibit, hold, fault next values
    always_comb begin
        // Unlatched hold until neutral
        hold_nxt = hold_r;
        if (any_inh) begin
            hold_nxt = 1'b1;
        end else if (!throttle_deflected) begin
            hold_nxt = 1'b0;
        end
        // Neutral check on inhibit, fault if still deflected
        check_nxt = inh_rise;
        fault_nxt = fault_r | (check_r & throttle_deflected & any_inh);
        inh_nxt = (|latched_r) | any_inh | hold_r | fault_r;
        // Slow limit handling
        edec_nxt = any_inh | (any_slow & (limit_r == 7'h0));
        brake_nxt = edec_nxt;
        ndec_nxt = any_slow & ~any_inh & (limit_r != 7'h0) & (limit_r < `DINH_LIMIT_MAX);
        slim_nxt = ndec_nxt;
    end

    // Drive registers; power cycle is the reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            latched_r <= '0;
            hold_r <= 1'b0;
            check_r <= 1'b0;
            fault_r <= 1'b0;
            inh_r <= 1'b0;
            edec_r <= 1'b0;
            brake_r <= 1'b0;
            ndec_r <= 1'b0;
            slim_r <= 1'b0;
            prev_inh_r <= 1'b0;
            lamp_r <= 1'b0;
        end else begin
            latched_r <= latched_nxt;
            hold_r <= hold_nxt;
            check_r <= check_nxt;
            fault_r <= fault_nxt;
            inh_r <= inh_nxt;
            edec_r <= edec_nxt;
            brake_r <= brake_nxt;
            ndec_r <= ndec_nxt;
            slim_r <= slim_nxt;
            prev_inh_r <= any_inh;
            lamp_r <= bl.lamp;
        end
    end

    // --------
    // Blink request
    // --------
    // Code per style
    always_comb begin
        bl.req = (|flash_want) | fault_r;
        bl.style = style_r;
        bl.code_lo = 4'h0;
        unique case (dinh_pkg::dinh_style_t'(style_r))
            dinh_pkg::DINH_STY_ALT2: bl.code_hi = `DINH_CODE_ALT2_INH;
            dinh_pkg::DINH_STY_T3: bl.code_hi = `DINH_CODE_T3_INH;
            dinh_pkg::DINH_STY_T4: begin
                bl.code_hi = `DINH_CODE_T4_HI;
                bl.code_lo = `DINH_CODE_T4_LO;
            end
            default: bl.code_hi = `DINH_CODE_STD_INH;
        endcase
    end

    dinh_blink #(.MS_CYC(MS_CYC)) u_blink (
        .clk_sys(clk_sys),
        .srst(srst),
        .bl(bl)
    );

    // --------
    // APB slave, one wait state
    // --------
    assign acc = psel & penable & ~pready_r;

    // Register next values
    always_comb begin
        cfg_nxt = cfg_r;
        limit_nxt = limit_r;
        style_nxt = style_r;
        prdata_nxt = prdata_r;
        pready_nxt = acc;
        pslverr_nxt = 1'b0;
        if (acc) begin
            prdata_nxt = 32'h0;
            unique case (paddr)
                `DINH_OFF_CFG0: begin
                    if (pwrite) cfg_nxt = pwdata;
                    prdata_nxt = cfg_r;
                end
                `DINH_OFF_CTRL: begin
                    if (pwrite) begin
                        limit_nxt = (pwdata[6:0] > `DINH_LIMIT_MAX) ? `DINH_LIMIT_MAX : pwdata[6:0];
                        style_nxt = (pwdata[10:8] > 3'h4) ? `DINH_RST_STYLE : pwdata[10:8];
                    end
                    prdata_nxt = {21'h0, style_r, 1'b0, limit_r};
                end
                `DINH_OFF_STAT: begin
                    prdata_nxt = {16'h0, 2'h0, latched_r, 2'h0, act,
                        2'h0, fault_r, hold_r, inh_r, edec_r, ndec_r, lamp_r};
                    pslverr_nxt = pwrite;
                end
                default: pslverr_nxt = 1'b1;
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_r <= `DINH_RST_CFG;
            limit_r <= `DINH_RST_LIMIT;
            style_r <= `DINH_RST_STYLE;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            limit_r <= limit_nxt;
            style_r <= style_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign drive_inhibit = inh_r;
    assign emergency_decel = edec_r;
    assign park_brake = brake_r;
    assign normal_decel = ndec_r;
    assign speed_limit_en = slim_r;
    assign slow_limit_percent = limit_r;
    assign out_of_neutral_power_up_check = check_r;
    assign out_of_neutral_power_up_check_fault = fault_r;
    assign status_lamp = lamp_r;
endmodule : dinh_top

/* verif/dinh_chk.sv */
`timescale 1ns/1ns
`include "dinh_defines.svh"
// Port checks on the inhibit, slow, blink and bus outputs
module dinh_chk #(
    parameter int MS_CYC = 50000
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic drive_inhibit,
    input wire logic emergency_decel,
    input wire logic park_brake,
    input wire logic normal_decel,
    input wire logic speed_limit_en,
    input wire logic [6:0] slow_limit_percent,
    input wire logic out_of_neutral_power_up_check,
    input wire logic out_of_neutral_power_up_check_fault,
    input wire logic status_lamp
);
    // --------
    // Lamp on-time counter
    // --------
    int on_cnt_r, on_cnt_nxt;
    always_comb begin
        on_cnt_nxt = status_lamp ? on_cnt_r + 1 : 0;
    end
    always_ff @(posedge clk_sys) begin
        on_cnt_r <= srst ? 0 : on_cnt_nxt;
    end

    // --------
    // Assertions
    // --------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_brake_pair: assert property (park_brake == emergency_decel)
        else $error("brake differs from decel");
    a_limit_pair: assert property (speed_limit_en == normal_decel)
        else $error("limit differs from decel");
    a_ends_no_normal: assert property
        ((slow_limit_percent == 7'h00 || slow_limit_percent == 7'h64) [*3] |-> !normal_decel)
        else $error("normal decel at end limit");
    a_fault_sticky: assert property (out_of_neutral_power_up_check_fault |=> out_of_neutral_power_up_check_fault)
        else $error("fault cleared");
    a_check_after_inh: assert property
        (out_of_neutral_power_up_check |-> drive_inhibit)
        else $error("check without inhibit");
    a_fault_cause: assert property
        ($rose(out_of_neutral_power_up_check_fault) |-> drive_inhibit || $past(drive_inhibit))
        else $error("fault without inhibit");
    a_lamp_cause: assert property
        ((!drive_inhibit && !out_of_neutral_power_up_check_fault) [*4] |-> !status_lamp)
        else $error("lamp without cause");
    a_lamp_on_max: assert property
        (status_lamp |-> on_cnt_r < `DINH_STD_ON_MS * MS_CYC)
        else $error("lamp on too long");
    a_pready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("no bus answer");
    a_pready_one: assert property (pready |=> !pready)
        else $error("ready too long");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule : dinh_chk

/* verif/dinh_far.sv */
`timescale 1ns/1ns
// Switch bank on the input pins and a watcher on the status light
module dinh_far (
    input wire logic clk_sys,
    input wire logic status_lamp,
    output logic [3:0] pin_level,
    output int rises,
    output int on_len,
    output int off_len
);
    int run = 0;
    logic lamp_q = 1'b0;
    initial begin
        pin_level = 4'h0;
        rises = 0;
    end

    // Switch moves land just after a clock edge and then hold
    task automatic set_pin(input int i, input logic [1:0] l);
        pin_level[i*2 +: 2] <= l;
    endtask : set_pin

    // Light watcher: counts blinks, keeps last on and off lengths
    always @(posedge clk_sys) begin
        if (status_lamp !== lamp_q) begin
            if (status_lamp === 1'b1) begin
                rises <= rises + 1;
                off_len <= run;
            end else begin
                on_len <= run;
            end
            run <= 1;
        end else begin
            run <= run + 1;
        end
        lamp_q <= status_lamp;
    end
endmodule : dinh_far

/* verif/dinh_top_bench.sv */
`timescale 1ns/1ns
`include "dinh_defines.svh"
module dinh_top_bench;
    localparam int MS = 2;
    localparam int W = 4000 * MS;
    localparam logic [17:0] MASKS = 18'b101_011_110_001_100_010;
    localparam logic [19:0] NBL = {4'd6, 4'd4, 4'd6, 4'd2, 4'd6};
    logic clk_sys = 1'b0, srst = 1'b1, throttle_deflected = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [3:0] pin_level;
    logic [6:0] slow_limit_percent;
    logic pready, pslverr, drive_inhibit, emergency_decel, park_brake, normal_decel;
    logic speed_limit_en, out_of_neutral_power_up_check, out_of_neutral_power_up_check_fault, status_lamp;
    int bad_count = 0, check_count = 0, cyc = 0;
    int rises, on_len, off_len;

    always #10 clk_sys = ~clk_sys;

    dinh_top #(.NPIN(2), .DEB_CYC(4), .MS_CYC(MS)) dinh_top_inst (
        .clk_sys(clk_sys), .srst(srst), .pin_level(pin_level),
        .throttle_deflected(throttle_deflected), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .drive_inhibit(drive_inhibit),
        .emergency_decel(emergency_decel), .park_brake(park_brake),
        .normal_decel(normal_decel), .speed_limit_en(speed_limit_en),
        .slow_limit_percent(slow_limit_percent),
        .out_of_neutral_power_up_check(out_of_neutral_power_up_check),
        .out_of_neutral_power_up_check_fault(out_of_neutral_power_up_check_fault), .status_lamp(status_lamp));
    dinh_far dinh_far_inst (.clk_sys(clk_sys), .status_lamp(status_lamp),
        .pin_level(pin_level), .rises(rises), .on_len(on_len), .off_len(off_len));

    // --------
    // Helpers
    // --------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] xr, input logic xe);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (!wr) chk("rdata", prdata, xr);
        chk("pslverr", {31'h0, pslverr}, {31'h0, xe});
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) bad_count++;
    endtask : apb

    task automatic cfg(input logic [7:0] b0, input logic [7:0] b1);
        apb(1'b1, `DINH_OFF_CFG0, {16'h0000, b1, b0}, 32'h0, 1'b0);
    endtask : cfg

    task automatic ctrl(input logic [6:0] lim, input logic [2:0] st);
        apb(1'b1, `DINH_OFF_CTRL, {21'h0, st, 1'b0, lim}, 32'h0, 1'b0);
    endtask : ctrl

    task automatic pin(input int i, input logic [1:0] l);
        @(posedge clk_sys);
        dinh_far_inst.set_pin(i, l);
        repeat (16) @(posedge clk_sys);
    endtask : pin

    task automatic thr(input logic v);
        @(posedge clk_sys);
        throttle_deflected <= v;
        repeat (6) @(posedge clk_sys);
    endtask : thr

    task automatic do_rst();
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
    endtask : do_rst

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            finish_test();
        end
    end

    // --------
    // Tests
    // --------
    initial begin
        int a, l, s, c0, onl, offl;
        do_rst();
        apb(1'b0, `DINH_OFF_CFG0, 32'h0, 32'h0, 1'b0);
        apb(1'b0, `DINH_OFF_CTRL, 32'h0, 32'h0000_0064, 1'b0);
        apb(1'b0, `DINH_OFF_CFG1, 32'h0, 32'h0, 1'b1);
        apb(1'b1, `DINH_OFF_STAT, 32'hffff_ffff, 32'h0, 1'b1);
        apb(1'b0, `DINH_OFF_STAT, 32'h0, 32'h0, 1'b0);
        // Every active state against the open, down and up pin levels
        for (a = 0; a < 6; a++) begin
            cfg({3'b000, a[2:0], 2'b01}, 8'h00);
            for (l = 0; l < 3; l++) begin
                pin(0, l[1:0]);
                chk("inhibit", {31'h0, drive_inhibit}, {31'h0, MASKS[a*3+l]});
            end
        end
        // Glitch shorter than the filter
        pin(0, 2'd0);
        dinh_far_inst.set_pin(0, 2'd1);
        pin(0, 2'd0);
        chk("glitch", {31'h0, drive_inhibit}, 32'h1);
        // Unlatched inhibit with flashing
        cfg(8'h45, 8'h00);
        pin(0, 2'd2);
        c0 = rises;
        repeat (40) @(posedge clk_sys);
        chk("no_flash", rises, c0);
        thr(1'b1);
        chk("flash", {31'h0, status_lamp}, 32'h1);
        pin(0, 2'd0);
        chk("held", {31'h0, drive_inhibit}, 32'h1);
        thr(1'b0);
        chk("freed", {31'h0, drive_inhibit}, 32'h0);
        thr(1'b1);
        pin(0, 2'd2);
        chk("fault", {31'h0, out_of_neutral_power_up_check_fault}, 32'h1);
        pin(0, 2'd0);
        thr(1'b0);
        chk("fault_kept", {31'h0, out_of_neutral_power_up_check_fault}, 32'h1);
        do_rst();
        chk("fault_rst", {31'h0, out_of_neutral_power_up_check_fault}, 32'h0);
        // Latched inhibit, flashing chosen alongside
        cfg(8'h65, 8'h00);
        pin(0, 2'd2);
        pin(0, 2'd0);
        chk("latched", {31'h0, drive_inhibit}, 32'h1);
        do_rst();
        chk("unlatched", {31'h0, drive_inhibit}, 32'h0);
        // Slow with latch bit set, then slow limits
        cfg(8'h26, 8'h00);
        ctrl(7'd50, 3'd0);
        pin(0, 2'd2);
        pin(0, 2'd0);
        chk("slow_nolatch", {31'h0, normal_decel}, 32'h0);
        pin(0, 2'd2);
        for (a = 0; a < 4; a++) begin
            ctrl(a == 0 ? 7'd0 : a == 1 ? 7'd127 : a == 2 ? 7'd100 : 7'd50, 3'd0);
            repeat (8) @(posedge clk_sys);
            chk("decel", {emergency_decel, park_brake, normal_decel, speed_limit_en},
                a == 0 ? 4'b1100 : a == 3 ? 4'b0011 : 4'b0000);
            chk("limit", slow_limit_percent, a == 0 ? 7'd0 : a == 3 ? 7'd50 : 7'd100);
        end
        pin(0, 2'd0);
        // Slow/stop on the second pin
        cfg(8'h00, 8'h0b);
        pin(1, 2'd2);
        chk("ss_open_stop", {31'h0, drive_inhibit}, 32'h0);
        pin(1, 2'd3);
        chk("ss_open_slow", {31'h0, normal_decel}, 32'h0);
        cfg(8'h00, 8'h07);
        pin(1, 2'd3);
        chk("ss_slow", {31'h0, normal_decel}, 32'h1);
        pin(1, 2'd2);
        chk("ss_stop", {31'h0, drive_inhibit}, 32'h1);
        pin(1, 2'd0);
        // Blink codes in every style
        pin(0, 2'd2);
        for (s = 0; s < 5; s++) begin
            do_rst();
            ctrl(7'd100, s[2:0]);
            cfg(8'h65, 8'h00);
            c0 = rises;
            repeat (300) if (rises == c0)
                @(posedge clk_sys);
            c0 = rises;
            offl = 0;
            onl = 0;
            repeat (W) begin
                @(posedge clk_sys);
                if (rises == c0 + 1 && offl == 0) begin
                    onl = on_len;
                    offl = off_len;
                end
            end
            chk("blinks", rises - c0 + 1, NBL[s*4 +: 4]);
            if (s != 1) begin
                chk("on_len", onl, (s == 4 ? `DINH_ALT_ON_MS : `DINH_STD_ON_MS) * MS);
                chk("off_len", offl, (s == 4 ? `DINH_ALT_OFF_MS : `DINH_STD_OFF_MS) * MS);
            end
        end
        finish_test();
    end
endmodule : dinh_top_bench

bind dinh_top dinh_chk #(.MS_CYC(MS_CYC)) dinh_chk_inst (.clk_sys(clk_sys), .srst(srst),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .drive_inhibit(drive_inhibit), .emergency_decel(emergency_decel),
    .park_brake(park_brake), .normal_decel(normal_decel), .speed_limit_en(speed_limit_en),
    .slow_limit_percent(slow_limit_percent),
    .out_of_neutral_power_up_check(out_of_neutral_power_up_check),
    .out_of_neutral_power_up_check_fault(out_of_neutral_power_up_check_fault), .status_lamp(status_lamp));
